// *** design/dual_sram_pkg.sv ***
`default_nettype none
package dual_sram_pkg;
    localparam int WORDS = 262144;
    localparam int WORD_W = 36;
    localparam int ADDR_W = 18;
    localparam logic [35:0] DOUT_RESET = 36'h0;
    localparam int POWERUP_CYCLES = 1;
endpackage
`default_nettype wire

// *** design/sram_array.sv ***
`timescale 1ns/1ps
`default_nettype none
// Two-port word array; Y write wins over X write at the same address
module sram_array #(
    parameter int DEPTH = 262144,
    parameter int AW = 18,
    parameter int DW = 36
) (
    input wire logic clk,
    input wire logic x_we,
    input wire logic [AW-1:0] x_addr,
    input wire logic [DW-1:0] x_wdata,
    input wire logic y_we,
    input wire logic [AW-1:0] y_addr,
    input wire logic [DW-1:0] y_wdata,
    output logic [DW-1:0] x_rdata,
    output logic [DW-1:0] y_rdata
);
    logic [DW-1:0] mem [DEPTH];

    // Reads are combinational on registered addresses: old data on collision
    assign x_rdata = mem[x_addr];
    assign y_rdata = mem[y_addr];

    always_ff @(posedge clk) begin
        if (x_we && !(y_we && y_addr == x_addr)) begin
            mem[x_addr] <= x_wdata;
        end
        if (y_we) begin
            mem[y_addr] <= y_wdata;
        end
    end
endmodule
`default_nettype wire

// *** design/dual_sync_sram.sv ***
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - All address, data, enable, write and pass inputs register on clk rise.
// - Input and output data paths of both buses are registered.
// - Array holds 262144 words of 36 bits, shared by both ports.
// - Each port has its own 18-bit word address.
// - Enabled port without pass-through: write select low writes, high reads.
// - Sel low high or sel high low at the edge deselects the port.
// - X pass asserted sends X registered input to Y output.
// - Y pass asserted sends Y registered input to X output.
// - Pass-through needs both ports enabled.
// - Pass-through beats a read on the receiving port.
// - Two reads of one address both return stored word.
// - Read against write at one address returns old contents.
// - Two writes to one address keep only Y data.
// - Output enable high floats the port's data pins.
module dual_sync_sram
    import dual_sram_pkg::*;
#(
    parameter int DEPTH = WORDS,
    parameter int AW = ADDR_W,
    parameter int DW = WORD_W
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [AW-1:0] port_x_word_addr,
    input wire logic [DW-1:0] port_x_data_bus_in,
    output logic [DW-1:0] port_x_data_bus_out,
    output logic port_x_data_bus_oe,
    input wire logic port_x_write_sel_n,
    input wire logic port_x_sel_low,
    input wire logic port_x_sel_high,
    input wire logic port_x_out_en_n,
    input wire logic pass_x_to_y_n,
    input wire logic [AW-1:0] port_y_word_addr,
    input wire logic [DW-1:0] port_y_data_bus_in,
    output logic [DW-1:0] port_y_data_bus_out,
    output logic port_y_data_bus_oe,
    input wire logic port_y_write_sel_n,
    input wire logic port_y_sel_low,
    input wire logic port_y_sel_high,
    input wire logic port_y_out_en_n,
    input wire logic pass_y_to_x_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Input registers, stage 1
    logic [AW-1:0] x_addr_q, y_addr_q;
    logic [DW-1:0] x_din_q, y_din_q;
    logic x_wsel_n_q, y_wsel_n_q, x_sl_q, x_sh_q, y_sl_q, y_sh_q;
    logic px_n_q, py_n_q;
    // Output registers, stage 2
    logic [DW-1:0] x_dout_q, y_dout_q;
    logic x_drive_q, y_drive_q;
    logic x_oe_q, y_oe_q;
    logic x_oen_meta_q, y_oen_meta_q;

    // A port is selected only with its low enable low and high enable high
    function automatic logic port_enabled(input logic sel_low,
        input logic sel_high);
        return !sel_low && sel_high;
    endfunction

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            x_addr_q <= '0;
            y_addr_q <= '0;
            x_din_q <= '0;
            y_din_q <= '0;
            x_wsel_n_q <= 1'b1;
            y_wsel_n_q <= 1'b1;
            x_sl_q <= 1'b1;
            x_sh_q <= 1'b0;
            y_sl_q <= 1'b1;
            y_sh_q <= 1'b0;
            px_n_q <= 1'b1;
            py_n_q <= 1'b1;
        end else begin
            x_addr_q <= port_x_word_addr;
            y_addr_q <= port_y_word_addr;
            x_din_q <= port_x_data_bus_in;
            y_din_q <= port_y_data_bus_in;
            x_wsel_n_q <= port_x_write_sel_n;
            y_wsel_n_q <= port_y_write_sel_n;
            x_sl_q <= port_x_sel_low;
            x_sh_q <= port_x_sel_high;
            y_sl_q <= port_y_sel_low;
            y_sh_q <= port_y_sel_high;
            px_n_q <= pass_x_to_y_n;
            py_n_q <= pass_y_to_x_n;
        end
    end

    wire x_en = port_enabled(x_sl_q, x_sh_q);
    wire y_en = port_enabled(y_sl_q, y_sh_q);
    wire both_en = x_en && y_en;
    wire pass_xy = both_en && !px_n_q;
    wire pass_yx = both_en && !py_n_q;
    wire no_pass = px_n_q && py_n_q;
    wire x_wr = x_en && !x_wsel_n_q;
    wire y_wr = y_en && !y_wsel_n_q;
    // Y wins a same-address double write; X's write is dropped
    wire x_store = x_wr && !(y_wr && x_addr_q == y_addr_q);
    wire x_rd = x_en && x_wsel_n_q && no_pass;
    wire y_rd = y_en && y_wsel_n_q && no_pass;
    wire [DW-1:0] x_rdata, y_rdata;

    sram_array #(.DEPTH(DEPTH), .AW(AW), .DW(DW)) u_array (
        .clk(clk),
        .x_we(x_store),
        .x_addr(x_addr_q),
        .x_wdata(x_din_q),
        .y_we(y_wr),
        .y_addr(y_addr_q),
        .y_wdata(y_din_q),
        .x_rdata(x_rdata),
        .y_rdata(y_rdata)
    );

    wire [DW-1:0] x_next = pass_yx ? y_din_q : x_rdata;
    wire [DW-1:0] y_next = pass_xy ? x_din_q : y_rdata;
    wire x_drive_d = pass_yx || x_rd;
    wire y_drive_d = pass_xy || y_rd;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            x_dout_q <= DOUT_RESET;
            y_dout_q <= DOUT_RESET;
            x_drive_q <= 1'b0;
            y_drive_q <= 1'b0;
            x_oen_meta_q <= 1'b1;
            y_oen_meta_q <= 1'b1;
            x_oe_q <= 1'b0;
            y_oe_q <= 1'b0;
        end else begin
            if (x_drive_d) begin
                x_dout_q <= x_next;
            end
            if (y_drive_d) begin
                y_dout_q <= y_next;
            end
            x_drive_q <= x_drive_d;
            y_drive_q <= y_drive_d;
            // Output enables are asynchronous pins, synchronised here
            x_oen_meta_q <= port_x_out_en_n;
            y_oen_meta_q <= port_y_out_en_n;
            x_oe_q <= !x_oen_meta_q;
            y_oe_q <= !y_oen_meta_q;
        end
    end

    assign port_x_data_bus_out = x_dout_q;
    assign port_y_data_bus_out = y_dout_q;
    assign port_x_data_bus_oe = x_oe_q;
    assign port_y_data_bus_oe = y_oe_q;

    // Pass-through data and the enables it needs
    AST_PASS_XY: assert property (
        pass_xy |=> y_dout_q == $past(x_din_q))
        else $error("Pass X to Y data wrong");
    AST_PASS_YX: assert property (
        pass_yx |=> x_dout_q == $past(y_din_q))
        else $error("Pass Y to X data wrong");
    AST_PASS_EN: assert property (
        !px_n_q && (x_sl_q || !x_sh_q || y_sl_q || !y_sh_q)
        |=> $stable(y_dout_q))
        else $error("Port Y changed on pass without both ports enabled");
    AST_PASS_EN_YX: assert property (
        !py_n_q && (x_sl_q || !x_sh_q || y_sl_q || !y_sh_q)
        |=> $stable(x_dout_q))
        else $error("Port X changed on pass without both ports enabled");

    // Deselected ports neither store nor load their output register
    AST_DESEL: assert property (
        (x_sl_q || !x_sh_q) |-> !x_wr ##1 $stable(x_dout_q))
        else $error("Deselected port X acted");
    AST_DESEL_Y: assert property (
        (y_sl_q || !y_sh_q) |-> !y_wr ##1 $stable(y_dout_q))
        else $error("Deselected port Y acted");

    // Reads and the output register
    AST_NO_RD_PASS: assert property (
        !no_pass |-> !x_rd && !y_rd)
        else $error("Read during pass cycle");
    AST_RD_LAT: assert property (
        x_rd |=> x_dout_q == $past(x_rdata))
        else $error("Read latency not one cycle");
    AST_RD_LAT_Y: assert property (
        y_rd |=> y_dout_q == $past(y_rdata))
        else $error("Port Y read latency not one cycle");
    AST_HOLD_X: assert property (
        !x_drive_q |-> $stable(x_dout_q))
        else $error("Port X output changed without read or pass");
    AST_HOLD_Y: assert property (
        !y_drive_q |-> $stable(y_dout_q))
        else $error("Port Y output changed without read or pass");

    // Output enables follow their synchronised pins
    AST_OE: assert property (
        $rose(x_oen_meta_q) |=> !port_x_data_bus_oe)
        else $error("Port X driving with enable high");
    AST_OE_Y: assert property (
        $rose(y_oen_meta_q) |=> !port_y_data_bus_oe)
        else $error("Port Y driving with enable high");
    AST_OE_ON_X: assert property (
        $fell(x_oen_meta_q) |=> port_x_data_bus_oe)
        else $error("Port X not driving with enable low");
    AST_OE_ON_Y: assert property (
        $fell(y_oen_meta_q) |=> port_y_data_bus_oe)
        else $error("Port Y not driving with enable low");

    // Input registers
    AST_INREG: assert property (
        ##1 x_addr_q == $past(port_x_word_addr))
        else $error("Address not registered");
    AST_INREG_Y: assert property (
        ##1 y_addr_q == $past(port_y_word_addr))
        else $error("Port Y address not registered");
    AST_WR_DIN_X: assert property (
        x_wr |-> x_din_q == $past(port_x_data_bus_in))
        else $error("Port X write data not registered");
    AST_WR_DIN_Y: assert property (
        y_wr |-> y_din_q == $past(port_y_data_bus_in))
        else $error("Port Y write data not registered");
endmodule
`default_nettype wire

// *** bench/host_port_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Resolves one data bus; a floating bus shows the inverse of its last level
module host_port_model (
    input wire logic clk,
    input wire logic dev_oe,
    input wire logic [35:0] dev_q,
    input wire logic host_oe,
    input wire logic [35:0] host_d,
    output logic [35:0] pin
);
    logic [35:0] last_q;
    always_ff @(posedge clk) last_q <= pin;
    // Host drives only while the device output is held off
    assign pin = dev_oe ? dev_q : (host_oe ? host_d : ~last_q);
endmodule
`default_nettype wire

// *** bench/test_dual_address_sync_sram_passthrough.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_dual_address_sync_sram_passthrough;
    import dual_sram_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0;
    logic [17:0] xa = 18'h0, ya = 18'h0;
    logic [35:0] xd = 36'h0, yd = 36'h0, xq, yq, xpin, ypin;
    logic xw = 1'b1, yw = 1'b1, xp = 1'b1, yp = 1'b1, xoen = 1'b1;
    logic xl = 1'b1, xh = 1'b0, yl = 1'b1, yh = 1'b0, xoe, yoe;
    logic yoen = 1'b1;
    int fails = 0, check_count = 0;
    always #20 clk = ~clk;
    host_port_model hx (.clk(clk), .dev_oe(xoe), .dev_q(xq), .host_oe(xoen),
        .host_d(xd), .pin(xpin));
    host_port_model hy (.clk(clk), .dev_oe(yoe), .dev_q(yq), .host_oe(yoen),
        .host_d(yd), .pin(ypin));
    dual_sync_sram dut (.clk(clk), .reset_n(reset_n),
        .port_x_word_addr(xa), .port_x_data_bus_in(xpin),
        .port_x_data_bus_out(xq), .port_x_data_bus_oe(xoe),
        .port_x_write_sel_n(xw), .port_x_sel_low(xl), .port_x_sel_high(xh),
        .port_x_out_en_n(xoen), .pass_x_to_y_n(xp),
        .port_y_word_addr(ya), .port_y_data_bus_in(ypin),
        .port_y_data_bus_out(yq), .port_y_data_bus_oe(yoe),
        .port_y_write_sel_n(yw), .port_y_sel_low(yl), .port_y_sel_high(yh),
        .port_y_out_en_n(yoen), .pass_y_to_x_n(yp));
    task automatic cyc(input logic [1:0] xs, input logic xwn, xpn,
        input logic [17:0] xad, input logic [35:0] xdd, input logic [1:0] ys,
        input logic ywn, ypn, input logic [17:0] yad, input logic [35:0] ydd);
        @(posedge clk);
        {xl, xh, xw, xp, xa, xd} <= {xs, xwn, xpn, xad, xdd};
        {yl, yh, yw, yp, ya, yd} <= {ys, ywn, ypn, yad, ydd};
    endtask
    task automatic idle();
        cyc(2'b11, 1, 1, 0, 0, 2'b00, 1, 1, 0, 0);
    endtask
    task automatic settle();
        idle();
        idle();
        #1;
    endtask
    task automatic chk(input logic [35:0] g, e);
        check_count++;
        if (g !== e) begin
            $display("Error at %0t: got %h expected %h", $time, g, e);
            fails++;
        end
    endtask
    task automatic s_rw();
        cyc(2'b01, 0, 1, 18'h3ffff, 36'h123456789, 2'b01, 0, 1, 2, 36'hfedcba987);
        idle();
        cyc(2'b01, 1, 1, 2, 0, 2'b01, 1, 1, 18'h3ffff, 0);
        settle();
        chk(xq, 36'hfedcba987);
        chk(yq, 36'h123456789);
        $display("test rw done");
    endtask
    task automatic s_coll();
        cyc(2'b01, 0, 1, 5, 36'h0aaaa5555, 2'b01, 0, 1, 5, 36'h05555aaaa);
        idle();
        cyc(2'b01, 1, 1, 5, 0, 2'b01, 1, 1, 5, 0);
        settle();
        chk(xq, 36'h05555aaaa);
        chk(yq, 36'h05555aaaa);
        cyc(2'b01, 0, 1, 5, 36'h0c3c3c3c3, 2'b01, 1, 1, 5, 0);
        settle();
        chk(yq, 36'h05555aaaa);
        cyc(2'b11, 1, 1, 0, 0, 2'b01, 1, 1, 5, 0);
        settle();
        chk(yq, 36'h0c3c3c3c3);
        $display("test collision done");
    endtask
    task automatic s_pass();
        cyc(2'b01, 1, 0, 0, 36'h9f0f0f0f0, 2'b01, 1, 1, 5, 0);
        settle();
        chk(yq, 36'h9f0f0f0f0);
        cyc(2'b01, 1, 1, 5, 0, 2'b01, 1, 0, 0, 36'h60f0f0f0f);
        settle();
        chk(xq, 36'h60f0f0f0f);
        cyc(2'b11, 0, 1, 2, 36'h111111111, 2'b00, 0, 1, 2, 36'h222222222);
        idle();
        cyc(2'b01, 1, 1, 2, 0, 2'b01, 1, 1, 2, 0);
        settle();
        chk(xq, 36'hfedcba987);
        chk(yq, 36'hfedcba987);
        cyc(2'b01, 1, 0, 0, 36'h333333333, 2'b00, 1, 1, 0, 0);
        settle();
        chk(yq, 36'hfedcba987);
        $display("test pass done");
    endtask
    task automatic s_oe();
        @(posedge clk) {xoen, yoen} <= 2'b00;
        repeat (2) @(posedge clk);
        #1 chk({34'h0, xoe, yoe}, 36'h3);
        chk(xpin, 36'hfedcba987);
        chk(ypin, 36'hfedcba987);
        @(posedge clk) {xoen, yoen} <= 2'b11;
        repeat (2) @(posedge clk);
        #1 chk({34'h0, xoe, yoe}, 36'h0);
        $display("test output enable done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 chk(xq, DOUT_RESET);
        chk(yq, DOUT_RESET);
        chk({34'h0, xoe, yoe}, 36'h0);
        // POWERUP_CYCLES idle cycles after reset release stand in for the power-up cycle
        @(posedge clk) reset_n <= 1'b1;
        repeat (POWERUP_CYCLES) idle();
        s_rw();
        s_coll();
        s_pass();
        s_oe();
        wrap_up();
    end
endmodule
`default_nettype wire
